/* src/tsr_regs.svh */
`ifndef TSR_REGS_SVH
`define TSR_REGS_SVH

// ==========================================================================
// Register selection codes
`define TSR_SEL_CAP       3'h0
`define TSR_SEL_CONF      3'h1
`define TSR_SEL_UPPER     3'h2
`define TSR_SEL_LOWER     3'h3
`define TSR_SEL_CRIT      3'h4
`define TSR_SEL_TEMP      3'h5
`define TSR_SEL_MAKER     3'h6
`define TSR_SEL_PARTREV   3'h7

// ==========================================================================
// Reset values and fixed contents
`define TSR_PTR_RESET     3'h0
`define TSR_RW_RESET      16'h0000
// Trips, high accuracy, signed range, 12-bit resolution; upper bits zero
`define TSR_CAP_VALUE     16'h001f
`define TSR_CAP_RSVD      11'h000
`define TSR_CAP_FIELDS    5'h1f

// ==========================================================================
// Bus framing
`define TSR_TYPE_ID       4'h3
`define TSR_BYTE_BITS     4'h8
`define TSR_BYTE_ADDR     3'h0
`define TSR_BYTE_PTR      3'h1
`define TSR_BYTE_HI       3'h2
`define TSR_BYTE_LO       3'h3
`define TSR_BYTE_EXTRA    3'h4

`endif

/* src/tsr_pkg.sv */
package tsr_pkg;

  // ========================================================================
  // Serial engine states, one-hot
  typedef enum logic [4:0]
  {
    TSR_IDLE = 5'b00001,
    TSR_RECV = 5'b00010,
    TSR_ACK  = 5'b00100,
    TSR_SEND = 5'b01000,
    TSR_MACK = 5'b10000
  } tsr_state_type;

endpackage

/* src/tsr_limit_store.sv */
`timescale 1ns/1ns
`include "tsr_regs.svh"

module tsr_limit_store
  import tsr_pkg::*;
(
  input  wire logic             i_clock,
  input  wire logic             i_arst_n,
  input  wire logic             i_we,
  input  wire logic [1:0]       i_waddr,
  input  wire logic [15:0]      i_wdata,
  input  wire logic [1:0]       i_raddr,
  output logic      [15:0]      o_rdata,
  output logic      [3:0][15:0] o_words
);

  // ========================================================================
  // Writable words: configuration and the three limits
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_word
      always_ff @(posedge i_clock or negedge i_arst_n)
      begin
        if (!i_arst_n)
          o_words[g] <= `TSR_RW_RESET;
        else if (i_we && (i_waddr == 2'(g)))
          o_words[g] <= i_wdata;
      end
    end
  endgenerate

  // ========================================================================
  // Registered read port
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_rdata <= `TSR_RW_RESET;
    else
      o_rdata <= o_words[i_raddr];
  end

endmodule

/* src/tsr_sensor_regs.sv */
`timescale 1ns/1ns
`include "tsr_regs.svh"

// Summary of operation
// [R1] Write-only pointer; low three bits select register
// [R2] Master sends pointer with bits 7..3 zero
// [R3] Codes 0..7 select the eight registers
// [R4] Master avoids illegal operations and reserved writes
// [R5] Selections 1..4 read/write, reset to zero
// [R6] Capability register reads fixed 001Fh
// [R7] Capability bit 0 reads one
// [R8] Capability bit 1 reads one
// [R9] Capability bit 2 reads one
// [R10] Capability bits 4:3 read binary 11
// [R11] Capability bits 15:5 read zero
// [R12] Selections 5..7 return temperature and identity codes
// [R13] Pointer clears to capability at reset
// [R14] Pointer holds its last written selection
// [R15] Writes carry address, pointer, two data bytes
// [R16] Upper byte first, MSB first in byte
// [R17] Writes to read-only selections change nothing
module tsr_sensor_regs
  import tsr_pkg::*;
#(
  parameter logic [15:0] MAKER_ID      = 16'h0a5a,  // Arbitrary value
  parameter logic [15:0] PART_REVISION = 16'h0101   // Arbitrary value
)
(
  input  wire logic        I_CLOCK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_SCL,
  input  wire logic        I_SDA,
  input  wire logic [2:0]  I_ADDR_SEL,
  input  wire logic [15:0] I_TEMPERATURE,
  output logic             O_SDA,
  output logic             O_SDA_OE,
  output logic      [15:0] O_CONFIGURATION,
  output logic      [15:0] O_UPPER_LIMIT,
  output logic      [15:0] O_LOWER_LIMIT,
  output logic      [15:0] O_CRITICAL_LIMIT
);

  // ========================================================================
  // Declarations
  tsr_state_type    state;
  logic [1:0]       scl_meta;
  logic [1:0]       sda_meta;
  logic [2:0]       sel_meta;
  logic [2:0]       sel_sync;
  logic             scl_sync;
  logic             sda_sync;
  logic             scl_prev;
  logic             sda_prev;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_cond;
  logic             stop_cond;
  logic [3:0]       bit_cnt;
  logic [7:0]       shift;
  logic [2:0]       byte_idx;
  logic             rw_read;
  logic             master_ack;
  logic             send_lo;
  logic             sda_low;
  logic [2:0]       pointer;
  logic [7:0]       wr_hi;
  logic [15:0]      wr_data;
  logic [15:0]      rd_word;
  logic [15:0]      sel_word;
  logic [15:0]      store_rdata;
  logic [3:0][15:0] store_words;
  logic [2:0]       sel_less_one;
  logic             byte_done;
  logic             addr_match;
  logic             reg_we;

  // Selections backed by the writable store
  function automatic logic is_writable(input logic [2:0] sel);
    is_writable = (sel >= `TSR_SEL_CONF) && (sel <= `TSR_SEL_CRIT);
  endfunction

  // ========================================================================
  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      sel_meta <= 3'h0;
      sel_sync <= 3'h0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_meta <= {scl_meta[0], I_SCL};
      sda_meta <= {sda_meta[0], I_SDA};
      sel_meta <= I_ADDR_SEL;
      sel_sync <= sel_meta;
      scl_prev <= scl_sync;
      sda_prev <= sda_sync;
    end
  end

  // Bus events seen on the clean copies
  assign scl_sync   = scl_meta[1];
  assign sda_sync   = sda_meta[1];
  assign scl_rise   = scl_sync && !scl_prev;
  assign scl_fall   = !scl_sync && scl_prev;
  assign start_cond = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop_cond  = scl_sync && scl_prev && !sda_prev && sda_sync;

  // Byte framing helpers
  assign byte_done  = (state == TSR_RECV) && scl_fall && (bit_cnt == `TSR_BYTE_BITS);
  assign addr_match = (shift[7:1] == {`TSR_TYPE_ID, sel_sync});
  assign wr_data    = {wr_hi, shift};                                   // [R16]
  // Read-only codes never raise the store's write strobe
  assign reg_we     = byte_done && (byte_idx == `TSR_BYTE_LO) && is_writable(pointer); // [R17]
  assign sel_less_one = pointer - 3'h1;

  // ========================================================================
  // Read selection; constants need no storage
  always_comb
  begin
    unique case (pointer)                                               // [R3]
      `TSR_SEL_CAP:     sel_word = `TSR_CAP_VALUE;                      // [R6]
      `TSR_SEL_TEMP:    sel_word = I_TEMPERATURE;                       // [R12]
      `TSR_SEL_MAKER:   sel_word = MAKER_ID;                            // [R12]
      `TSR_SEL_PARTREV: sel_word = PART_REVISION;                       // [R12]
      default:          sel_word = store_rdata;                         // [R5]
    endcase
  end

  // ========================================================================
  // Pointer: only the three low bits are kept
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      pointer <= `TSR_PTR_RESET;                                        // [R13]
    else if (byte_done && (byte_idx == `TSR_BYTE_PTR))
      pointer <= shift[2:0];                                            // [R1] [R14]
  end

  // Upper data byte waits for its partner
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      wr_hi <= 8'h00;
    else if (byte_done && (byte_idx == `TSR_BYTE_HI))
      wr_hi <= shift;                                                   // [R16]
  end

  // ========================================================================
  // Serial engine
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      state      <= TSR_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      byte_idx   <= `TSR_BYTE_ADDR;
      rw_read    <= 1'b0;
      master_ack <= 1'b0;
      send_lo    <= 1'b0;
      sda_low    <= 1'b0;
      rd_word    <= 16'h0000;
    end
    else if (start_cond)
    begin
      // Repeated start restarts framing anywhere
      state    <= TSR_RECV;
      bit_cnt  <= 4'h0;
      byte_idx <= `TSR_BYTE_ADDR;
      sda_low  <= 1'b0;
    end
    else if (stop_cond)
    begin
      state   <= TSR_IDLE;
      sda_low <= 1'b0;
    end
    else
    begin
      unique case (state)
        TSR_IDLE:
          sda_low <= 1'b0;
        TSR_RECV:
        begin
          if (scl_rise)
          begin
            shift   <= {shift[6:0], sda_sync};                          // [R16]
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (byte_done)
          begin
            // Unknown address or a surplus data byte is not acknowledged
            if (((byte_idx == `TSR_BYTE_ADDR) && !addr_match) ||
                (byte_idx == `TSR_BYTE_EXTRA))
              state <= TSR_IDLE;
            else
            begin
              state   <= TSR_ACK;
              sda_low <= 1'b1;
            end
            if (byte_idx == `TSR_BYTE_ADDR)
              rw_read <= shift[0];
            if (byte_idx != `TSR_BYTE_EXTRA)
              byte_idx <= byte_idx + 3'h1;
          end
        end
        TSR_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            if (rw_read)
            begin
              // Snapshot whole word so both bytes agree
              state   <= TSR_SEND;
              rd_word <= sel_word;
              shift   <= sel_word[15:8];                                // [R16]
              sda_low <= !sel_word[15];
              send_lo <= 1'b0;
            end
            else
            begin
              state   <= TSR_RECV;
              sda_low <= 1'b0;
            end
          end
        end
        TSR_SEND:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == 4'h7)
            begin
              state   <= TSR_MACK;
              sda_low <= 1'b0;
            end
            else
            begin
              shift   <= {shift[6:0], 1'b0};                            // [R16]
              sda_low <= !shift[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        TSR_MACK:
        begin
          if (scl_rise)
            master_ack <= !sda_sync;
          else if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            if (master_ack)
            begin
              // Further reads alternate lower then upper byte
              state   <= TSR_SEND;
              shift   <= send_lo ? rd_word[15:8] : rd_word[7:0];
              sda_low <= send_lo ? !rd_word[15] : !rd_word[7];
              send_lo <= !send_lo;
            end
            else
              state <= TSR_IDLE;
          end
        end
        default:
        begin
          state   <= TSR_IDLE;
          sda_low <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================================
  // Writable store and pin drive
  tsr_limit_store u_store
  (
    .i_clock  (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_we     (reg_we),
    .i_waddr  (sel_less_one[1:0]),
    .i_wdata  (wr_data),
    .i_raddr  (sel_less_one[1:0]),
    .o_rdata  (store_rdata),
    .o_words  (store_words)
  );

  // Open drain: only ever pulls low
  assign O_SDA            = 1'b0;
  assign O_SDA_OE         = sda_low;
  assign O_CONFIGURATION  = store_words[0];
  assign O_UPPER_LIMIT    = store_words[1];
  assign O_LOWER_LIMIT    = store_words[2];
  assign O_CRITICAL_LIMIT = store_words[3];

  // ========================================================================
  // Assertions
  ptr_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [R14] [R1]
    !$stable(pointer) |-> $past(byte_done && (byte_idx == `TSR_BYTE_PTR)))
    else $error("pointer changed outside a pointer byte");

  cap_fields_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [R7] [R8] [R9] [R10] [R11]
    (pointer == `TSR_SEL_CAP) |-> (sel_word[4:0] == `TSR_CAP_FIELDS) &&
                                  (sel_word[15:5] == `TSR_CAP_RSVD))
    else $error("capability fields wrong");

  ro_write_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [R17]
    reg_we |-> is_writable(pointer) && (byte_idx == `TSR_BYTE_LO))
    else $error("store written from a read-only selection");

  conf_write_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [R5] [R3]
    (reg_we && (pointer == `TSR_SEL_CONF)) |=> (O_CONFIGURATION == $past(wr_data)))
    else $error("configuration did not take written word");

  crit_keep_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [R17] [R3]
    (reg_we && (pointer != `TSR_SEL_CRIT)) |=> $stable(O_CRITICAL_LIMIT))
    else $error("critical limit disturbed by another write");

  ident_sel_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [R12]
    ((pointer == `TSR_SEL_PARTREV) |-> (sel_word == PART_REVISION)) and
    ((pointer == `TSR_SEL_TEMP) |-> (sel_word == I_TEMPERATURE)))
    else $error("identity or temperature selection wrong");

  hi_first_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [R16]
    (state == TSR_ACK && scl_fall && rw_read && !start_cond && !stop_cond) |=>
      (state == TSR_SEND) && (shift == rd_word[15:8]) && (sda_low == !rd_word[15]))
    else $error("read did not open with upper byte MSB");

  ack_drive_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // [R15]
    (byte_done && addr_match && (byte_idx == `TSR_BYTE_ADDR) && !start_cond && !stop_cond)
      |=> O_SDA_OE [*1] ##0 (state == TSR_ACK))
    else $error("matching address not acknowledged");

endmodule

/* verification/tsr_bus_master.sv */
`timescale 1ns/1ns

// ==========================================================================
// Bus master model; lines it releases float high through the pull-up
module tsr_bus_master
(
  input  wire logic i_clock,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  // Each bus phase gets five clocks, above the four-clock minimum
  localparam int HALF = 5;

  initial
  begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  task automatic tick();
    repeat (HALF) @(posedge i_clock);
    #1;
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start();
    o_sda_oe = 1'b0;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda_oe = 1'b1;
    tick();
    o_scl = 1'b0;
    tick();
  endtask

  // Stop: data rises while the clock is high
  task automatic stop();
    o_sda_oe = 1'b1;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda_oe = 1'b0;
    tick();
  endtask

  // Data only changes a full phase after the clock fall, keeping hold time
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      o_sda_oe = ~b[i];
      tick();
      o_scl = 1'b1;
      tick();
      o_scl = 1'b0;
      tick();
    end
    o_sda_oe = 1'b0;
    tick();
    o_scl = 1'b1;
    tick();
    ack = ~i_sda;
    o_scl = 1'b0;
    tick();
  endtask

  // Sampled late in the high phase; last byte is refused to end the read
  task automatic get_byte(input logic last, output logic [7:0] b);
    o_sda_oe = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      tick();
      o_scl = 1'b1;
      tick();
      b[i] = i_sda;
      o_scl = 1'b0;
    end
    tick();
    o_sda_oe = ~last;
    tick();
    o_scl = 1'b1;
    tick();
    o_scl = 1'b0;
    tick();
    // Acknowledge is released by the next byte or the stop, not here
  endtask
endmodule

/* verification/tb_tsr_sensor_regs.sv */
`timescale 1ns/1ns
`include "tsr_regs.svh"

`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module tb_tsr_sensor_regs;
  localparam logic [15:0] MAKER = 16'h5a3c;  // Arbitrary value
  localparam logic [15:0] PREV  = 16'h0c21;  // Arbitrary value
  localparam logic [2:0]  STRAP = 3'h5;

  logic        clk;
  logic        arst_n;
  logic        scl;
  logic        m_oe;
  logic        dut_sda;
  logic        dut_oe;
  logic [15:0] temp;
  logic [15:0] conf;
  logic [15:0] upper;
  logic [15:0] lower;
  logic [15:0] crit;
  logic [15:0] rd;
  logic [15:0] exp_tab [8];
  logic [2:0]  ro [4];
  logic        nack_bit;
  wire logic   sda;
  int          fail_count;
  int          n_compared;

  // ========================================================================
  // Open-drain wire: low if either side pulls, else pulled up
  assign sda = (dut_oe ? dut_sda : 1'b1) & ~m_oe;

  tsr_sensor_regs #(
    .MAKER_ID      (MAKER),
    .PART_REVISION (PREV)
  ) u_dut (
    .I_CLOCK          (clk),
    .I_ARST_N         (arst_n),
    .I_SCL            (scl),
    .I_SDA            (sda),
    .I_ADDR_SEL       (STRAP),
    .I_TEMPERATURE    (temp),
    .O_SDA            (dut_sda),
    .O_SDA_OE         (dut_oe),
    .O_CONFIGURATION  (conf),
    .O_UPPER_LIMIT    (upper),
    .O_LOWER_LIMIT    (lower),
    .O_CRITICAL_LIMIT (crit)
  );

  tsr_bus_master u_master (
    .i_clock  (clk),
    .i_sda    (sda),
    .o_scl    (scl),
    .o_sda_oe (m_oe)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ========================================================================
  // Result, reset and bus tasks
  task automatic results();
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic reset_dut();
    arst_n = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask

  // Address, pointer, two data bytes; an extra byte must be refused
  task automatic write_reg(input logic [2:0] sel, input logic [15:0] data, input logic extra);
    logic       ack;
    logic [7:0] bytes [4];
    bytes = '{{`TSR_TYPE_ID, STRAP, 1'b0}, {5'h00, sel}, data[15:8], data[7:0]};
    u_master.start();
    for (int i = 0; i < 4; i++)
    begin
      u_master.put_byte(bytes[i], ack);
      `CHK(ack, 1'b1)
    end
    if (extra)
    begin
      u_master.put_byte(8'h5a, ack);
      `CHK(ack, 1'b0)
    end
    u_master.stop();
  endtask

  // Optional pointer write, then repeated start and a two-byte read
  task automatic read_reg(input logic setp, input logic [2:0] sel, output logic [15:0] data);
    logic ack;
    if (setp)
    begin
      u_master.start();
      u_master.put_byte({`TSR_TYPE_ID, STRAP, 1'b0}, ack);
      u_master.put_byte({5'h00, sel}, ack);
    end
    u_master.start();
    u_master.put_byte({`TSR_TYPE_ID, STRAP, 1'b1}, ack);
    `CHK(ack, 1'b1)
    u_master.get_byte(1'b0, data[15:8]);
    u_master.get_byte(1'b1, data[7:0]);
    u_master.stop();
  endtask

  // ========================================================================
  // Bounded run
  initial
  begin
    repeat (90000) @(posedge clk);
    fail_count++;
    results();
  end

  // ========================================================================
  // Main sequence
  initial
  begin
    fail_count = 0;
    n_compared = 0;
    temp = 16'hff90;
    ro = '{3'h0, 3'h5, 3'h6, 3'h7};
    reset_dut();
    `CHK({conf, upper, lower, crit}, 64'h0)
    read_reg(1'b0, 3'h0, rd);
    `CHK(rd, 16'h001f)
    `CHK(rd[0], 1'b1)
    `CHK(rd[1], 1'b1)
    `CHK(rd[2], 1'b1)
    `CHK(rd[4:3], 2'b11)
    `CHK(rd[15:5], 11'h000)
    // Distinct, asymmetric words catch swapped bytes or bit order
    for (int s = 1; s <= 4; s++)
      write_reg(3'(s), 16'h81c0 + 16'(s), 1'b0);
    `CHK({conf, upper, lower, crit}, {16'h81c1, 16'h81c2, 16'h81c3, 16'h81c4})
    exp_tab = '{16'h001f, 16'h81c1, 16'h81c2, 16'h81c3, 16'h81c4, temp, MAKER, PREV};
    for (int s = 0; s < 8; s++)
    begin
      read_reg(1'b1, 3'(s), rd);
      `CHK(rd, exp_tab[s])
    end
    read_reg(1'b0, 3'h0, rd);
    `CHK(rd, PREV)
    // Read-only places must ignore writes and leave the limits alone
    foreach (ro[i])
      write_reg(ro[i], 16'hffff, 1'b0);
    `CHK({conf, upper, lower, crit}, {16'h81c1, 16'h81c2, 16'h81c3, 16'h81c4})
    foreach (ro[i])
    begin
      read_reg(1'b1, ro[i], rd);
      `CHK(rd, exp_tab[ro[i]])
    end
    write_reg(3'h2, 16'h0f0f, 1'b1);
    `CHK(upper, 16'h0f0f)
    // Another strap setting on the bus must be ignored
    u_master.start();
    u_master.put_byte({`TSR_TYPE_ID, STRAP ^ 3'h1, 1'b0}, nack_bit);
    `CHK(nack_bit, 1'b0)
    u_master.stop();
    // Second reset after the pointer moved away from zero
    reset_dut();
    `CHK({conf, upper, lower, crit}, 64'h0)
    read_reg(1'b0, 3'h0, rd);
    `CHK(rd, 16'h001f)
    results();
  end
endmodule
